// File: hdl/psc_clock_manager.sv
// module: power-save state machine, reduced CPU clock divider, module gating, APB slave
`timescale 1ns/10ps
`default_nettype none
module psc_clock_manager
  import psc_pkg::*;
#(
  parameter int NMOD = 16
)(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            powerSaveInstr,
  input  wire logic            sleepOperand,
  input  wire logic            irqPending,
  input  wire logic            watchdogTimeout,
  input  wire logic            watchdogEnabled,
  input  wire logic            monitorCfgEn,
  input  wire logic            oscIsOnChip,
  input  wire logic [2:0]      activeSource,
  input  wire logic [NMOD-1:0] modPresent,
  input  wire logic [NMOD-1:0] modRegSel,
  output psc_clk_s             clkCtrl,
  output logic                 cpuClkEnable,
  output logic                 cpuRestart,
  output logic [2:0]           resumeSource,
  output logic [NMOD-1:0]      modEnable,
  output logic [NMOD-1:0]      modRegBlock,
  output logic [1:0]           modeState
);
  psc_state_e       state_r, state_nxt;
  logic [15:0]      divCtl_r;
  logic [NMOD-1:0]  gate_r;
  logic [NMOD-1:0]  gateDly_r;
  logic [6:0]       dozeCnt_r;
  logic [2:0]       ratioAct_r;
  logic             dozeAct_r;
  logic [1:0]       restartCnt_r;
  logic [2:0]       source_r;
  logic             heldIrq_r;
  logic [1:0]       restartCnt_nxt;

  // decode of the bus access; accesses finish in a single access cycle
  wire logic apbWr    = psel & penable & pwrite;
  wire logic selDiv   = (paddr == ADDR_DIVIDER);
  wire logic selGate  = (paddr == ADDR_GATE);
  wire logic selStat  = (paddr == ADDR_STATUS);
  wire logic mapped   = selDiv | selGate | selStat;
  wire logic wakeEvt  = irqPending | watchdogTimeout | heldIrq_r;
  wire logic enterCmd = powerSaveInstr & (state_r == PSC_RUN);
  wire logic dozeEn   = divCtl_r[BIT_REDUCED];
  wire logic [2:0] ratioSel = divCtl_r[BIT_RATIO_HI:BIT_RATIO_LO];
  wire logic retHit   = divCtl_r[BIT_RET_IRQ] & irqPending & (state_r == PSC_RUN);

  // divisor 2**n: the counter's mask picks the low n bits
  function automatic logic [6:0] ratioMask(input logic [2:0] r);
    ratioMask = 7'((8'h01 << r) - 8'h01);
  endfunction

  wire logic [6:0] actMask  = ratioMask(ratioAct_r);
  wire logic       boundary = ((dozeCnt_r & actMask) == 7'h00);
  wire logic       cpuTick  = ~dozeAct_r | boundary;

  // power-save sequencing
  always_comb
  begin
    state_nxt      = state_r;
    restartCnt_nxt = restartCnt_r;
    unique case (state_r)
      PSC_RUN:
        if (powerSaveInstr)
          state_nxt = sleepOperand ? PSC_SLEEP : PSC_IDLE;
      PSC_SLEEP, PSC_IDLE:
        if (wakeEvt)
        begin
          state_nxt      = PSC_RESTART;
          restartCnt_nxt = RESTART_LOAD;
        end
      PSC_RESTART:
        if (restartCnt_r == 2'd0)
          state_nxt = PSC_RUN;
        else
          restartCnt_nxt = restartCnt_r - 2'd1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r      <= PSC_RUN;
      restartCnt_r <= 2'd0;
      heldIrq_r    <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      restartCnt_r <= restartCnt_nxt;
      heldIrq_r    <= enterCmd & irqPending;
    end
  end

  // source captured at entry, held through sleep
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      source_r <= 3'd0;
    else if (enterCmd)
      source_r <= activeSource;
  end

  // software registers; a write in the same cycle beats the interrupt clear
  // so that software never loses a value it has just programmed
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      divCtl_r <= DIVIDER_RESET;
      gate_r   <= GATE_RESET[NMOD-1:0];
    end
    else
    begin
      if (apbWr & selDiv)
        divCtl_r <= pwdata[15:0] & DIVIDER_WMASK;
      else if (retHit)
        divCtl_r[BIT_REDUCED] <= 1'b0;
      if (apbWr & selGate)
        gate_r <= pwdata[NMOD-1:0];
    end
  end

  // divider: counter reloads to 1 on each boundary; ratio and enable latched only on a boundary
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dozeCnt_r  <= 7'h00;
      ratioAct_r <= 3'd0;
      dozeAct_r  <= 1'b0;
    end
    else
    begin
      dozeCnt_r <= dozeCnt_r + 7'h01;
      if (boundary)
      begin
        ratioAct_r <= ratioSel;
        dozeAct_r  <= dozeEn;
        dozeCnt_r  <= 7'h01;
      end
    end
  end

  // gate change delayed one instruction cycle (one CPU tick)
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      gateDly_r <= GATE_RESET[NMOD-1:0];
    else if (cpuTick)
      gateDly_r <= gate_r;
  end

  wire logic [NMOD-1:0] modOn = ~gateDly_r & modPresent;
  wire logic inSleep = (state_nxt == PSC_SLEEP);
  wire logic cpuRun  = (state_nxt == PSC_RUN);

  // registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      clkCtrl      <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      cpuClkEnable <= 1'b1;
      cpuRestart   <= 1'b0;
      resumeSource <= 3'd0;
      modEnable    <= '0;
      modRegBlock  <= '0;
      modeState    <= 2'd0;
    end
    else
    begin
      clkCtrl.sysClkEn  <= ~inSleep;
      clkCtrl.oscEn     <= ~(inSleep & oscIsOnChip);
      clkCtrl.cpuClkEn  <= cpuRun;
      clkCtrl.monitorEn <= monitorCfgEn & ~inSleep;
      clkCtrl.lowPowerRcEn  <= inSleep ? watchdogEnabled
                                       : (watchdogEnabled | monitorCfgEn);
      clkCtrl.watchdogClear <= enterCmd & watchdogEnabled;
      cpuClkEnable      <= cpuRun & cpuTick;
      cpuRestart        <= (state_r == PSC_RESTART) & (state_nxt == PSC_RUN);
      resumeSource      <= source_r;
      modEnable         <= inSleep ? '0 : modOn;
      modRegBlock       <= ~modOn;
      modeState         <= state_nxt;
    end
  end

  // APB read path, zero wait states
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= selDiv  ? {16'h0000, divCtl_r}
                : selGate ? 32'(gate_r)
                : selStat ? {24'h00_0000, 1'b0, dozeAct_r, source_r, 1'b0, state_r}
                : INVALID_DATA;
    end
  end

  // checks: every property here lives on ref_clk and is quiet in reset
  // outputs are registered from state_nxt, so a property that samples
  // state_r sees the matching output value in the same cycle
  // the held-interrupt wake and the restart pulse are several steps, so they are built from sequences
  default clocking chkClk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // entry with an interrupt in the same cycle
  sequence s_enter_with_irq;
    enterCmd & irqPending;
  endsequence

  // last restart cycle followed by the first run cycle
  sequence s_leave_restart;
    (state_r == PSC_RESTART) ##1 (state_r == PSC_RUN);
  endsequence

  // sleep entry drops the system clock on the next cycle
  chk_sleep_stops: assert property (
    (enterCmd & sleepOperand)
    |=> !clkCtrl.sysClkEn)
    else $error("sleep kept clock");

  // idle keeps the system clock
  chk_idle_keeps: assert property (
    (state_r == PSC_IDLE)
    |-> ##1 clkCtrl.sysClkEn)
    else $error("idle lost clock");

  // idle stops the CPU clock and its tick
  chk_idle_cpu_off: assert property (
    (state_r == PSC_IDLE)
    |-> (!clkCtrl.cpuClkEn && !cpuClkEnable))
    else $error("cpu clock in idle");

  // time-out ends sleep
  chk_wake_exit: assert property (
    ((state_r == PSC_SLEEP) & watchdogTimeout)
    |=> (state_r == PSC_RESTART))
    else $error("no wake");

  // enabled interrupt ends idle
  chk_idle_wake: assert property (
    ((state_r == PSC_IDLE) & irqPending)
    |=> (state_r == PSC_RESTART))
    else $error("no idle wake");

  // on-chip source is switched off in sleep
  chk_osc_off: assert property (
    ((state_r == PSC_SLEEP) & $past(oscIsOnChip))
    |-> !clkCtrl.oscEn)
    else $error("osc on in sleep");

  // failure monitor has nothing to watch in sleep
  chk_monitor_off: assert property (
    (state_r == PSC_SLEEP)
    |-> !clkCtrl.monitorEn)
    else $error("monitor in sleep");

  // watchdog keeps its slow oscillator in sleep
  chk_rc_sleep: assert property (
    ((state_r == PSC_SLEEP) & $past(watchdogEnabled))
    |-> clkCtrl.lowPowerRcEn)
    else $error("rc off in sleep");

  // watchdog count cleared on every entry while enabled
  chk_watchdog_clear: assert property (
    (enterCmd & watchdogEnabled)
    |=> clkCtrl.watchdogClear)
    else $error("watchdog not cleared");

  // no module clock survives sleep
  chk_sleep_mods: assert property (
    (state_r == PSC_SLEEP)
    |-> (modEnable == '0))
    else $error("module clock in sleep");

  // source reported at wake is the one seen at entry
  chk_resume_src: assert property (
    enterCmd
    |=> ##1 (resumeSource == $past(activeSource, 2)))
    else $error("resume source");

  // slow oscillator stays up in idle for watchdog or monitor
  chk_rc_idle: assert property (
    ((state_r == PSC_IDLE) & $past(watchdogEnabled | monitorCfgEn))
    |-> clkCtrl.lowPowerRcEn)
    else $error("rc off in idle");

  // restart lasts 2 to 4 cycles
  chk_restart_len: assert property (
    $rose(state_r == PSC_RESTART)
    |-> ##[2:4] (state_r == PSC_RUN))
    else $error("restart length");

  // restart pulse marks the first run cycle
  chk_restart_pulse: assert property (
    s_leave_restart
    |-> cpuRestart)
    else $error("restart pulse missing");

  // coincident interrupt still enters, then wakes at once
  chk_held_irq: assert property (
    s_enter_with_irq
    |=> ##1 (state_r == PSC_RESTART))
    else $error("held irq lost");

  // full speed ticks every cycle while running
  chk_full_speed: assert property (
    (!dozeAct_r & (state_nxt == PSC_RUN))
    |=> cpuClkEnable)
    else $error("missing cpu tick");

  // reduced mode never ticks between boundaries
  chk_doze_gap: assert property (
    (dozeAct_r & !boundary)
    |=> !cpuClkEnable)
    else $error("tick off boundary");

  // enable bit is taken at a boundary
  chk_reduced_take: assert property (
    boundary
    |=> (dozeAct_r == $past(dozeEn)))
    else $error("enable not taken");

  // ratio code is taken at a boundary
  chk_ratio_take: assert property (
    boundary
    |=> (ratioAct_r == $past(ratioSel)))
    else $error("ratio not taken");

  // interrupt with the return bit drops reduced mode
  chk_ret_irq: assert property (
    (retHit & !(apbWr & selDiv))
    |=> !divCtl_r[BIT_REDUCED])
    else $error("no return to full speed");

  // gated module has its registers blocked
  chk_gate_block: assert property (
    (modRegBlock & $past(gateDly_r)) == $past(gateDly_r))
    else $error("gated registers open");

  // absent module is never enabled
  chk_gate_enable: assert property (
    (modEnable & ~$past(modPresent)) == '0)
    else $error("absent module enabled");

  // ratio and enable frozen off a boundary, so no short CPU pulse
  chk_ratio_hold: assert property (
    !boundary
    |=> ($stable(ratioAct_r) && $stable(dozeAct_r)))
    else $error("ratio changed mid period");

  // gate change applied one tick later
  chk_gate_delay: assert property (
    ($changed(gate_r) & ~dozeAct_r)
    |=> (gateDly_r == $past(gate_r)))
    else $error("gate delay");
endmodule
`default_nettype wire

// File: hdl/psc_pkg.sv
// package: constants, types and rule summary for the power-save clock manager
// Functional notes
// - sleep operand of power-save instruction stops system clock and halts execution
// - idle operand stops CPU only; peripherals keep clock unless gated
// - sleep or idle ends on enabled interrupt, any reset, or watchdog time-out
// - sleep shuts down system clock source including on-chip oscillator
// - clock failure monitor is off during sleep
// - low-power RC keeps running in sleep when watchdog enabled
// - watchdog count cleared on entry to sleep and on entry to idle
// - sleep disables system-clocked peripherals; change notify and ext-clock ones continue (here modEnable clears every module in sleep)
// - wake from sleep resumes on the clock source active at entry
// - idle keeps system clock; RC oscillator on if watchdog or monitor enabled
// - idle wake reapplies CPU clock; execution restarts 2 to 4 cycles later
// - interrupt coincident with instruction held until entry completes, then wakes
// - reduced mode divides only CPU clock; system clock and peripherals unchanged
// - CPU and peripheral domains stay synchronous in reduced mode
// - bit 11 enables reduced CPU clock; clear runs CPU at peripheral speed
// - bits 14:12 pick ratio among eight, 1:1 to 1:128, default 1:1
// - bit 15 set lets interrupt restore full speed; default no effect
// - gated module loses all clocks; its registers ignore writes, read invalid
// - module enabled only if gate clear and present; present ones default enabled
// - a gate bit change takes effect after one instruction cycle
package psc_pkg;
  localparam logic [11:0] ADDR_DIVIDER    = 12'h0000;
  localparam logic [11:0] ADDR_GATE       = 12'h0004;
  localparam logic [11:0] ADDR_STATUS     = 12'h0008;
  localparam int          BIT_RET_IRQ     = 15;
  localparam int          BIT_RATIO_HI    = 14;
  localparam int          BIT_RATIO_LO    = 12;
  localparam int          BIT_REDUCED     = 11;
  localparam logic [15:0] DIVIDER_RESET   = 16'h0000;
  localparam logic [15:0] DIVIDER_WMASK   = 16'hF800;
  localparam logic [31:0] INVALID_DATA    = 32'h0000_0000;
  localparam int          RESTART_CYCLES  = 3;
  localparam logic [1:0]  RESTART_LOAD    = 2'(RESTART_CYCLES - 1);
  localparam logic [31:0] GATE_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {PSC_RUN, PSC_SLEEP, PSC_IDLE, PSC_RESTART} psc_state_e;

  typedef struct packed {
    logic sysClkEn;
    logic cpuClkEn;
    logic oscEn;
    logic lowPowerRcEn;
    logic monitorEn;
    logic watchdogClear;
  } psc_clk_s;
endpackage

// File: verification/psc_core_model.sv
// core-side model: issues power-save instructions and raises interrupts
`timescale 1ns/10ps
`default_nettype none
module psc_core_model (
  input  wire logic ref_clk,
  input  wire logic cpuRestart,
  output logic      powerSaveInstr,
  output logic      sleepOperand,
  output logic      irqPending
);
  initial {powerSaveInstr, sleepOperand, irqPending} = 3'b000;
  // request stays pending until the handler starts, as a real source would
  always @(posedge ref_clk)
    if (cpuRestart)
      irqPending <= 1'b0;
  // one-cycle instruction strobe; an interrupt may coincide with it
  task automatic exec(input logic slp, input logic irq);
    powerSaveInstr <= 1'b1;
    sleepOperand   <= slp;
    irqPending     <= irq;
    @(posedge ref_clk);
    powerSaveInstr <= 1'b0;
  endtask
  task automatic set_irq(input logic v);
    irqPending <= v;
  endtask
endmodule
`default_nettype wire

// File: verification/psc_clock_manager_tb_top.sv
// self-checking bench for the power-save clock manager
`timescale 1ns/10ps
`default_nettype none
module psc_clock_manager_tb_top;
  import psc_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, e, cpuClkEnable, cpuRestart;
  logic        watchdogTimeout = 1'b0, watchdogEnabled = 1'b0;
  logic        monitorCfgEn = 1'b0, oscIsOnChip = 1'b1;
  logic [2:0]  activeSource = 3'h0, resumeSource;
  logic [15:0] modPresent = 16'h0000, modRegSel = 16'h0000, modEnable, modRegBlock;
  logic [1:0]  modeState;
  psc_clk_s    clkCtrl;
  wire         powerSaveInstr, sleepOperand, irqPending;
  int          num_errors = 0, tests_run = 0, divM = 0, gateM = 0;
  int          ticks = 0, clears = 0, restarts = 0, parked = 0, t0, c0, r0, p0, w;

  psc_clock_manager #(.NMOD(16)) psc_clock_manager_inst (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .powerSaveInstr, .sleepOperand,
    .irqPending, .watchdogTimeout, .watchdogEnabled, .monitorCfgEn, .oscIsOnChip,
    .activeSource,
    .modPresent, .modRegSel, .clkCtrl, .cpuClkEnable, .cpuRestart, .resumeSource,
    .modEnable, .modRegBlock, .modeState);
  psc_core_model core_inst (.ref_clk, .cpuRestart, .powerSaveInstr, .sleepOperand,
    .irqPending);

  always #5 ref_clk = ~ref_clk;
  // event counters; non-blocking so the main sequence sees one stable value
  always @(posedge ref_clk)
  begin
    ticks    <= ticks + int'(cpuClkEnable);
    clears   <= clears + int'(clkCtrl.watchdogClear);
    restarts <= restarts + int'(cpuRestart);
    parked   <= parked + int'(modeState != 2'd0);
  end

  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one APB transfer, entered just after an edge; holds until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // write with model update, read compared against the model
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    if (a == ADDR_DIVIDER)
      divM = d & int'(DIVIDER_WMASK);
    else
      gateM = d & 32'h0000_FFFF;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
    chk("regRead", (a == ADDR_DIVIDER) ? divM : gateM, q);
  endtask

  initial
  begin
    #300us;
    num_errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(84));
    modPresent <= 16'($urandom);
    modRegSel  <= 16'($urandom);
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("modEnable", modPresent, modEnable);
    rd(ADDR_DIVIDER);
    rd(ADDR_GATE);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("pslverr", 1, e);
    // gating: random masks, present modules only
    repeat (2)
    begin
      wr(ADDR_GATE, $urandom);
      rd(ADDR_GATE);
      chk("modEnable", modPresent & ~gateM[15:0], modEnable);
      chk("modRegBlock", gateM[15:0] & modPresent, modRegBlock & modPresent);
    end
    // every ratio code; long settle lets the divider reach a tick boundary
    for (int n = 0; n < 8; n++)
    begin
      wr(ADDR_DIVIDER, 32'h0000_0800 | (n << 12));
      rd(ADDR_DIVIDER);
      repeat (300) @(posedge ref_clk);
      t0 = ticks;
      repeat (256) @(posedge ref_clk);
      chk("cpuTicks", 256 >> n, ticks - t0);
      chk("sysClkEn", 1, clkCtrl.sysClkEn);
    end
    // interrupt without then with the return bit
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_DIVIDER, 32'h0000_2800 | (k << 15));
      core_inst.set_irq(1'b1);
      repeat (20) @(posedge ref_clk);
      core_inst.set_irq(1'b0);
      divM = (k == 1) ? divM & ~32'h0000_0800 : divM;
      rd(ADDR_DIVIDER);
    end
    wr(ADDR_DIVIDER, 0);
    // 0: sleep woken by time-out, 1: idle woken by irq, 2: irq with instruction
    for (int k = 0; k < 3; k++)
    begin
      watchdogEnabled <= (k != 1);
      monitorCfgEn <= 1'b1;
      activeSource <= 3'($urandom);
      @(posedge ref_clk);
      c0 = clears;
      r0 = restarts;
      p0 = parked;
      core_inst.exec(k != 1, k == 2);
      if (k < 2)
      begin
        repeat (4) @(posedge ref_clk);
        chk("modeState", k + 1, modeState);
        chk("sysClkEn", k, clkCtrl.sysClkEn);
        chk("oscEn", k, clkCtrl.oscEn);
        chk("monitorEn", k, clkCtrl.monitorEn);
        chk("lowPowerRcEn", 1, clkCtrl.lowPowerRcEn);
        chk("cpuClkEnable", 0, cpuClkEnable);
        chk("watchdogClear", k != 1, clears - c0);
        chk("resumeSource", activeSource, resumeSource);
        if (k == 1)
          chk("modEnable", modPresent & ~gateM[15:0], modEnable);
        if (k == 0)
          watchdogTimeout <= 1'b1;
        else
          core_inst.set_irq(1'b1);
        @(posedge ref_clk);
        watchdogTimeout <= 1'b0;
      end
      w = 0;
      while (restarts == r0 && w < 40)
      begin
        @(posedge ref_clk);
        w++;
      end
      if (k == 1)
        chk("wakeDelay", 1, w >= 2 && w <= 6);
      chk("restarts", 1, restarts - r0);
      chk("entered", 1, parked > p0);
      repeat (4) @(posedge ref_clk);
      chk("runState", 0, modeState);
      chk("sysClkOn", 1, clkCtrl.sysClkEn);
    end
    end_sim();
  end
endmodule
`default_nettype wire
